// [hw/spc_regs_map.svh]
// Purpose: offsets, field positions and reset values of the slot registers
// Assumes: byte-wide register port, command code selects the register
// Notes: definitions only
`ifndef SPC_REGS_MAP_SVH
`define SPC_REGS_MAP_SVH

`define SPC_OFS_CTRL_A 8'h02
`define SPC_OFS_CTRL_B 8'h03
`define SPC_OFS_STAT_A 8'h04
`define SPC_OFS_STAT_B 8'h05

`define SPC_RST_CTRL 8'h00
`define SPC_RST_STAT 8'h00
`define SPC_RST_BYTE 8'h00

// control register fields
`define SPC_CTRL_AUX_PG 7
`define SPC_CTRL_MAIN_PG 6
`define SPC_CTRL_MAIN_ON 1
`define SPC_CTRL_AUX_ON 0

// status register fields; flags sit in the low five bits
`define SPC_STAT_FAULT_PIN 7
`define SPC_STAT_MAIN_STATE 6
`define SPC_STAT_AUX_STATE 5
`define SPC_STAT_FLAG_MSB 4

`endif

// [hw/spc_pkg.sv]
// Purpose: shared types of the slot power register bank
// Assumes: nothing beyond the map header
// Notes: flag order is aux, minus 12, plus 12, five, three (msb first)
package spc_pkg;
  typedef logic [7:0] spc_byte_t;
  typedef logic [4:0] spc_flags_t;
endpackage

// [hw/spc_slot_power_regs.sv]
// Purpose: per-slot power control and status registers of a two-slot
//   hot-plug power controller
// Assumes: byte reads and writes by command code from a management bus
//   front end on the same clock; every slot signal arrives from pins
// Notes: index 0 is slot A, index 1 is slot B
`timescale 1ns/10ps
`include "spc_regs_map.svh"

// Notes on behaviour
// [R1] Ctrl bits 7/6 read aux/main power good, 5..2 zero, 1/0 main/aux on.
// [R2] After reset both control registers are zero, all supplies off.
// [R3] Codes 02h, 03h, 04h select ctrl A, ctrl B, status A, read and write.
// [R4] Status A: fault pin, main state, aux state in 7..5, flags in 4..0.
// [R5] Status bits 4..0 flag aux, -12 V, +12 V, 5 V and 3 V overcurrent.
// [R6] Writing one to a flag clears it; the interrupt output releases once no flag of either slot is set.
// [R7] Reading a status register does not touch the slot fault pin.
// [R8] Slot B status has the same layout as slot A.
// [R9] The fault pin status bit reads one while the fault pin is low.
// [R10] A slot under bus path control keeps fault bit and fault pin inactive.
// [R11] A flag is set by a supply trip and stays set until written with one.
module spc_slot_power_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  input wire logic [1:0] mainPowerGood,
  input wire logic [1:0] auxPowerGood,
  input wire logic [1:0] mainOutState,
  input wire logic [1:0] auxOutState,
  input wire logic [1:0] smbusPathCtrl,
  input wire logic [9:0] overcurrentTrip,
  input wire logic [1:0] faultPinIn,
  output logic [1:0] faultPinOut,
  output logic [1:0] faultPinOe,
  output logic [1:0] mainOn,
  output logic [1:0] auxOn,
  output logic intOutN
);

  localparam int SyncW = 22;

  logic [SyncW-1:0] syncA_r;
  logic [SyncW-1:0] syncB_r;
  logic [1:0] mainOn_r;
  logic [1:0] auxOn_r;
  spc_pkg::spc_flags_t flags_r [2];
  spc_pkg::spc_flags_t flags_nxt [2];
  spc_pkg::spc_byte_t regRdata_r;
  logic regRvalid_r;
  logic [1:0] faultPinOe_r;
  logic [1:0] faultPinOut_r;
  logic intOutN_r;

  logic [1:0] pgMain;
  logic [1:0] pgAux;
  logic [1:0] stMain;
  logic [1:0] stAux;
  logic [1:0] smbCtrl;
  logic [1:0] faultLow;
  logic [9:0] trip;

  // pins are asynchronous to clock; only syncB_r is read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {mainPowerGood, auxPowerGood, mainOutState, auxOutState,
                  smbusPathCtrl, overcurrentTrip, ~faultPinIn};
      syncB_r <= syncA_r;
    end
  end

  assign pgMain = syncB_r[21:20];
  assign pgAux = syncB_r[19:18];
  assign stMain = syncB_r[17:16];
  assign stAux = syncB_r[15:14];
  assign smbCtrl = syncB_r[13:12];
  assign trip = syncB_r[11:2];
  assign faultLow = syncB_r[1:0];

  function automatic spc_pkg::spc_byte_t ctrlByte(input logic s);
    ctrlByte = `SPC_RST_BYTE;
    ctrlByte[`SPC_CTRL_AUX_PG] = pgAux[s]; // [R1]
    ctrlByte[`SPC_CTRL_MAIN_PG] = pgMain[s]; // [R1]
    ctrlByte[`SPC_CTRL_MAIN_ON] = mainOn_r[s];
    ctrlByte[`SPC_CTRL_AUX_ON] = auxOn_r[s];
  endfunction

  function automatic spc_pkg::spc_byte_t statByte(input logic s);
    statByte = `SPC_RST_BYTE;
    // bus-controlled slot never reports the pin
    statByte[`SPC_STAT_FAULT_PIN] = faultLow[s] & ~smbCtrl[s]; // [R9] [R10]
    statByte[`SPC_STAT_MAIN_STATE] = stMain[s]; // [R4] [R8]
    statByte[`SPC_STAT_AUX_STATE] = stAux[s]; // [R4] [R8]
    statByte[`SPC_STAT_FLAG_MSB:0] = flags_r[s]; // [R5]
  endfunction

  // control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mainOn_r <= 2'h0; // [R2]
      auxOn_r <= 2'h0; // [R2]
    end else if (regWrite) begin
      if (regAddr == `SPC_OFS_CTRL_A) begin // [R3]
        mainOn_r[0] <= regWdata[`SPC_CTRL_MAIN_ON]; // [R1]
        auxOn_r[0] <= regWdata[`SPC_CTRL_AUX_ON]; // [R1]
      end
      if (regAddr == `SPC_OFS_CTRL_B) begin // [R3]
        mainOn_r[1] <= regWdata[`SPC_CTRL_MAIN_ON];
        auxOn_r[1] <= regWdata[`SPC_CTRL_AUX_ON];
      end
    end
  end

  // sticky flags; a trip in the clearing cycle wins over the clear
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      flags_nxt[s] = flags_r[s] | trip[s*5 +: 5]; // [R11]
    end
    if (regWrite && regAddr == `SPC_OFS_STAT_A) begin // [R3]
      flags_nxt[0] = (flags_r[0] & ~regWdata[4:0]) | trip[4:0]; // [R6]
    end
    if (regWrite && regAddr == `SPC_OFS_STAT_B) begin
      flags_nxt[1] = (flags_r[1] & ~regWdata[4:0]) | trip[9:5]; // [R6] [R8]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_r[0] <= 5'h00;
      flags_r[1] <= 5'h00;
    end else begin
      flags_r[0] <= flags_nxt[0];
      flags_r[1] <= flags_nxt[1];
    end
  end

  // read port: answer one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdata_r <= `SPC_RST_BYTE;
      regRvalid_r <= 1'b0;
    end else begin
      regRvalid_r <= regRead;
      if (regRead) begin
        unique case (regAddr)
          `SPC_OFS_CTRL_A: regRdata_r <= ctrlByte(1'b0); // [R3]
          `SPC_OFS_CTRL_B: regRdata_r <= ctrlByte(1'b1); // [R3]
          `SPC_OFS_STAT_A: regRdata_r <= statByte(1'b0); // [R4]
          `SPC_OFS_STAT_B: regRdata_r <= statByte(1'b1); // [R8]
          default: regRdata_r <= `SPC_RST_BYTE;
        endcase
      end
    end
  end

  // fault pin follows the flags and bus path control, never the read strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      faultPinOe_r <= 2'h0;
      faultPinOut_r <= 2'h0;
    end else begin
      faultPinOut_r <= 2'h0;
      faultPinOe_r[0] <= (|flags_r[0]) & ~smbCtrl[0]; // [R7] [R10]
      faultPinOe_r[1] <= (|flags_r[1]) & ~smbCtrl[1]; // [R7] [R10]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      intOutN_r <= 1'b1;
    end else begin
      intOutN_r <= ~(|flags_r[0] | |flags_r[1]); // [R6]
    end
  end

  assign regRdata = regRdata_r;
  assign regRvalid = regRvalid_r;
  assign mainOn = mainOn_r;
  assign auxOn = auxOn_r;
  assign faultPinOe = faultPinOe_r;
  assign faultPinOut = faultPinOut_r;
  assign intOutN = intOutN_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ctrl_reset_off_a: assert property ($past(sys_rst) |-> // [R2]
    mainOn == 2'h0 && auxOn == 2'h0)
    else $error("supplies not off after reset");

  ctrl_write_a: assert property ( // [R1]
    regWrite && regAddr == `SPC_OFS_CTRL_A |=>
    mainOn[0] == $past(regWdata[1]) && auxOn[0] == $past(regWdata[0]))
    else $error("slot A enables not written");

  ctrl_read_zero_a: assert property ( // [R1]
    regRead && regAddr == `SPC_OFS_CTRL_B |=>
    regRdata[5:2] == 4'h0 && regRdata[1] == $past(mainOn[1]) &&
    regRdata[0] == $past(auxOn[1]))
    else $error("slot B control read wrong");

  stat_pin_bit_a: assert property ( // [R9]
    regRead && regAddr == `SPC_OFS_STAT_A |=>
    regRdata[7] == ($past(faultLow[0]) && !$past(smbCtrl[0])))
    else $error("fault pin status bit wrong");

  stat_b_flags_a: assert property ( // [R8]
    regRead && regAddr == `SPC_OFS_STAT_B |=>
    regRdata[4:0] == $past(flags_r[1]) && regRvalid)
    else $error("slot B flags read wrong");

  flag_clear_a: assert property ( // [R6]
    regWrite && regAddr == `SPC_OFS_STAT_A && regWdata[4] && !trip[4] |=>
    !flags_r[0][4])
    else $error("flag not cleared by one");

  flag_sticky_a: assert property (flags_r[0][0] && !regWrite |=> // [R11]
    flags_r[0][0])
    else $error("flag dropped without clear");

  int_follow_a: assert property (##1 intOutN == // [R6]
    !(|$past(flags_r[0]) || |$past(flags_r[1])))
    else $error("interrupt does not follow flags");

  read_no_pin_a: assert property ( // [R7]
    regRead && !regWrite && trip == 10'h000 && smbCtrl == $past(smbCtrl)
    ##1 $stable(flags_r[0]) && $stable(smbCtrl[0]) |=>
    $stable(faultPinOe[0]))
    else $error("status read moved the fault pin");

  smb_no_fault_a: assert property (smbCtrl[1] |=> !faultPinOe[1]) // [R10]
    else $error("fault pin active under bus control");

  trip_cov_c: cover property (trip[0] ##1 flags_r[0][0] ##[1:5] !intOutN);
  clear_cov_c: cover property (!intOutN ##1 regWrite ##[1:3] intOutN);
  stat_read_cov_c: cover property (regRead && regAddr == `SPC_OFS_STAT_B
    && flags_r[1] != 5'h00);

endmodule // spc_slot_power_regs

// [verification/spc_slot_model.sv]
// Purpose: slot power hardware seen by the register bank
// Assumes: outputs follow the enables one clock later
// Notes: power good trails the output state by one more clock
`timescale 1ns/10ps
module spc_slot_model (
  input wire logic clock,
  input wire logic [1:0] mainOn,
  input wire logic [1:0] auxOn,
  output logic [1:0] mainOutState,
  output logic [1:0] auxOutState,
  output logic [1:0] mainPowerGood,
  output logic [1:0] auxPowerGood
);
  // rails need a clock to ramp before power good shows
  always @(posedge clock) begin
    mainOutState <= mainOn;
    auxOutState <= auxOn;
    mainPowerGood <= mainOutState;
    auxPowerGood <= auxOutState;
  end
endmodule // spc_slot_model

// [verification/spc_tb.sv]
// Purpose: self-checking bench of the slot power register bank
// Assumes: strobes driven at the falling edge, one byte per strobe
// Notes: fault pins have a pull-up, so a released pin reads high
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic clock, sys_rst, regWrite, regRead;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regRvalid, intOutN;
  logic [1:0] mainPowerGood, auxPowerGood, mainOutState, auxOutState;
  logic [1:0] smbusPathCtrl, faultPinIn, faultPinOut, faultPinOe;
  logic [1:0] mainOn, auxOn;
  logic [9:0] overcurrentTrip;
  int n_fail, n_tests, cycles;
  // released pin floats up to the pull-up level
  assign faultPinIn = ~faultPinOe | faultPinOut;
  spc_slot_power_regs i_spc_slot_power_regs (.clock(clock),
    .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .mainPowerGood(mainPowerGood),
    .auxPowerGood(auxPowerGood), .mainOutState(mainOutState),
    .auxOutState(auxOutState), .smbusPathCtrl(smbusPathCtrl),
    .overcurrentTrip(overcurrentTrip), .faultPinIn(faultPinIn),
    .faultPinOut(faultPinOut), .faultPinOe(faultPinOe), .mainOn(mainOn),
    .auxOn(auxOn), .intOutN(intOutN));
  spc_slot_model i_spc_slot_model (.clock(clock), .mainOn(mainOn),
    .auxOn(auxOn), .mainOutState(mainOutState), .auxOutState(auxOutState),
    .mainPowerGood(mainPowerGood), .auxPowerGood(auxPowerGood));
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    `CHK(regRvalid, 1'b1)
    `CHK(regRdata, e)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // the whole sequence needs about a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {regWrite, regRead, regAddr, regWdata} = 18'h0_0000;
    smbusPathCtrl = 2'h0;
    overcurrentTrip = 10'h000;
    sys_rst = 1'b1;
    idle(8);
    sys_rst = 1'b0;
    `CHK({mainOn, auxOn, intOutN}, 5'h01)
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'h02);
    `CHK({mainOn, auxOn}, 4'hD)
    idle(6);
    rd(8'h02, 8'hC3);
    rd(8'h03, 8'h42);
    rd(8'h04, 8'h60);
    overcurrentTrip = 10'h008;
    idle(5);
    overcurrentTrip = 10'h000;
    idle(4);
    `CHK({intOutN, faultPinOe[0]}, 2'h1)
    rd(8'h04, 8'hE8);
    rd(8'h04, 8'hE8);
    `CHK({faultPinOe[0], faultPinOut[0]}, 2'h2)
    wr(8'h04, 8'h00);
    rd(8'h04, 8'hE8);
    wr(8'h04, 8'h08);
    idle(4);
    `CHK({intOutN, faultPinOe[0]}, 2'h2)
    rd(8'h04, 8'h60);
    overcurrentTrip = 10'h020;
    idle(5);
    overcurrentTrip = 10'h000;
    idle(4);
    rd(8'h05, 8'hC1);
    wr(8'h05, 8'h01);
    idle(4);
    rd(8'h05, 8'h40);
    smbusPathCtrl = 2'h2;
    overcurrentTrip = 10'h200;
    idle(5);
    overcurrentTrip = 10'h000;
    idle(4);
    `CHK({intOutN, faultPinOe[1]}, 2'h0)
    rd(8'h05, 8'h50);
    wr(8'h05, 8'h1F);
    idle(4);
    `CHK(intOutN, 1'b1)
    finish_test();
  end
endmodule // tb
